// >>> src/rxt_pkg.sv
// Package for the receiver timing, correction and clock-output registers.
// Assumes a byte-wide register port and a single 250 MHz clock domain.
`default_nettype none
package rxt_pkg;
	// Register offsets.
	localparam logic [7:0] ADDR_CORR_CTRL   = 8'h1A;
	localparam logic [7:0] ADDR_CORR_HIGH   = 8'h1B;
	localparam logic [7:0] ADDR_CORR_LOW    = 8'h1C;
	localparam logic [7:0] ADDR_ERR_HIGH    = 8'h1D;
	localparam logic [7:0] ADDR_ERR_LOW     = 8'h1E;
	localparam logic [7:0] ADDR_PRE_CFG     = 8'h1F;
	localparam logic [7:0] ADDR_RSSI_TO     = 8'h20;
	localparam logic [7:0] ADDR_PRE_TO      = 8'h21;
	localparam logic [7:0] ADDR_SYNC_TO     = 8'h22;
	localparam logic [7:0] ADDR_DELAY       = 8'h23;
	localparam logic [7:0] ADDR_OSC         = 8'h24;
	localparam logic [7:0] ADDR_SYNC_CFG    = 8'h27;
	localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h3E;
	localparam logic [7:0] ADDR_IRQ_MASK    = 8'h3F;
	// Reset values.
	localparam logic [7:0] RST_PRE_CFG      = 8'hAA;
	localparam logic [2:0] RST_CLK_SEL      = 3'h7;
	localparam logic [1:0] RST_POLICY       = 2'h2;
	// Field positions.
	localparam int PRE_EN_BIT   = 7;
	localparam int PRE_LEN_LSB  = 5;
	localparam int CAL_BIT      = 3;
	localparam int CLR_BIT      = 1;
	localparam int POLICY_LSB   = 6;
	// Field codes.
	localparam logic [2:0] CLK_RC       = 3'h6;
	localparam logic [2:0] CLK_OFF      = 3'h7;
	localparam logic [1:0] POLICY_NOWAIT = 2'h1;
	localparam logic [1:0] POLICY_PLL    = 2'h2;
	localparam logic [1:0] LEN_RESERVED  = 2'h3;
	// Log2 of the bit periods per unit of the timeout and restart-delay settings.
	localparam int TIMEOUT_UNIT_LOG2 = 4;
	localparam int RESTART_UNIT_LOG2 = 2;
	// Interrupt status bit positions.
	localparam int IRQ_RSSI_TO  = 0;
	localparam int IRQ_PRE_TO   = 1;
	localparam int IRQ_SYNC_TO  = 2;
	localparam int IRQ_RESTART  = 3;
	localparam int IRQ_W        = 4;
	// Automatic restart sequencer states.
	typedef enum logic [1:0] {RS_IDLE, RS_DELAY, RS_PLL} rxt_rs_t;
endpackage : rxt_pkg
`default_nettype wire

// >>> src/rxt_wait_timer.sv
// Bit-period wait timer used for receive timeouts and the restart delay.
// Assumes a one-cycle bit tick and start pulse; stop may be held high for many cycles.
`default_nettype none
module rxt_wait_timer
	import rxt_pkg::*;
#(
	parameter int UNIT_LOG2 = 4
)
(
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       rst,
	// Control.
	input  wire logic       tick,
	input  wire logic       start,
	input  wire logic       stop,
	input  wire logic [7:0] limit,
	// Expiry pulse.
	output logic            done
);
	typedef struct packed {
		logic        run;
		logic [11:0] count;
		logic        done;
	} rxt_timer_t;

	rxt_timer_t s;
	rxt_timer_t next_s;
	logic [11:0] target;

	// A zero setting never arms the timer, which is how it is disabled.
	assign target = {4'h0, limit} << UNIT_LOG2;

	// Restart wins over stop so a fresh entry always begins a full wait.
	always_comb
	begin
		next_s = s;
		next_s.done = 1'b0;
		if (start)
		begin
			next_s.run = (limit != 8'h00); // R16
			next_s.count = 12'h000;
		end
		else if (s.run && stop)
			next_s.run = 1'b0; // R16
		else if (s.run && tick)
		begin
			next_s.count = s.count + 12'h001;
			if (s.count + 12'h001 == target)
			begin
				next_s.done = 1'b1;
				next_s.run = 1'b0;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			s <= '0;
		else
			s <= next_s;
	end

	assign done = s.done;

	// Expiry only follows a counted tick while armed.
	property p_done_cause;
		@(posedge clk) disable iff (rst)
		s.done |-> $past(s.run) && $past(tick) && !$past(start);
	endproperty
	a_done_cause: assert property (p_done_cause) // R16
		else $error("timer expired without a running count");

	// A stop while armed ends the wait silently.
	property p_stop_quiet;
		@(posedge clk) disable iff (rst)
		s.run && stop && !start |=> !s.run && !s.done;
	endproperty
	a_stop_quiet: assert property (p_stop_quiet) // R16
		else $error("timer not stopped by its event");
endmodule : rxt_wait_timer
`default_nettype wire

// >>> src/rxt_regs.sv
// Receiver timing, frequency correction and clock-output register bank.
// Assumes a byte register port, event pulses on this clock, rc_osc async.
// Functional notes
// R1: The 16-bit signed correction is held in two byte registers and a write replaces the value in use.
// R2: Software reads the error high byte first so both bytes come from one measurement.
// R3: The error readout is a signed count of synthesizer frequency steps.
// R4: The preamble detector runs only when enabled, except that gain control overrides it during its phase.
// R5: The length code selects one, two or three preamble bytes, with code 11 reserved.
// R6: A 5-bit field sets the tolerated chip errors over the length, four chips per bit.
// R7: A nonzero RSSI setting raises a timeout after setting times 16 bit periods without an RSSI event.
// R8: A nonzero preamble setting raises a timeout after setting times 16 bit periods without a preamble event.
// R9: A nonzero sync setting raises a timeout after setting times 16 bit periods without a sync match.
// R10: An automatic restart waits an extra setting times four bit periods first.
// R11: Writing one to the calibration trigger starts RC calibration and the bit reads as zero.
// R12: Software triggers RC calibration only in standby; the bank starts calibration on the trigger write in receive mode as well.
// R13: The clock select drives the reference divided by 1 to 32, the RC clock, or nothing.
// R14: Writing the clear bit in receive mode zeroes the correction, and the bit reads as zero.
// R15: The restart policy selects off, restart at once, or restart after PLL lock, with 11 reserved.
// R16: Each timeout restarts on every receive entry and stops silently on its event or on leaving receive.
// R17: The bit period comes from the programmed bit rate so delays scale with it.
`default_nettype none
module rxt_regs
	import rxt_pkg::*;
(
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rst,
	// Register port.
	input  wire logic [7:0]  addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [7:0]  rdata,
	// Receiver status and events.
	input  wire logic        rx_mode,
	input  wire logic [15:0] bit_period_cycles,
	input  wire logic        rssi_event,
	input  wire logic        preamble_event,
	input  wire logic        sync_match_event,
	input  wire logic        valid_packet,
	input  wire logic        pll_locked,
	input  wire logic        agc_phase,
	input  wire logic        agc_detect_request,
	// Correction loop and error measurement.
	input  wire logic        afc_load,
	input  wire logic [15:0] afc_value,
	input  wire logic [15:0] freq_error_estimate,
	output logic      [15:0] freq_correction_value,
	// Preamble detector control.
	output logic             preamble_detect_run,
	output logic      [1:0]  preamble_bytes_required,
	output logic      [4:0]  preamble_chip_error_tolerance,
	// Receiver control and events.
	output logic             timeout_event,
	output logic             rx_restart,
	output logic             rc_calibrate_start,
	output logic             irq,
	// Clock output.
	input  wire logic        rc_osc,
	output logic             rc_osc_enable,
	output logic             aux_clock_pin
);
	typedef struct packed {
		logic [15:0]      corr;
		logic [7:0]       err_low;
		logic [7:0]       pre_cfg;
		logic [7:0]       rssi_lim;
		logic [7:0]       pre_lim;
		logic [7:0]       sync_lim;
		logic [7:0]       delay;
		logic [2:0]       clk_sel;
		logic [1:0]       policy;
		logic [IRQ_W-1:0] status;
		logic [IRQ_W-1:0] mask;
		logic [7:0]       rdata;
		logic             rx_prev;
		logic [15:0]      bit_cnt;
		logic             bit_tick;
		rxt_rs_t          rs;
		logic             restart;
		logic             cal;
		logic             timeout;
		logic             irq;
		logic             pre_run;
		logic [1:0]       pre_bytes;
		logic [2:0]       rc_sync;
		logic             rc_level;
		logic [5:0]       div;
		logic             aux;
		logic             rc_en;
	} rxt_state_t;

	rxt_state_t s;
	rxt_state_t next_s;

	logic rx_entry;
	logic rx_exit;
	logic rssi_done;
	logic pre_done;
	logic sync_done;
	logic delay_done;
	logic restart_req;
	logic delay_start;
	logic policy_on;

	// Receive entry rearms every timeout; leaving receive stops them.
	assign rx_entry = rx_mode && !s.rx_prev;
	assign rx_exit  = !rx_mode;
	assign policy_on = (s.policy == POLICY_NOWAIT)
		|| (s.policy == POLICY_PLL); // R15
	assign restart_req = (s.rs == RS_IDLE) && valid_packet && policy_on;
	assign delay_start = restart_req && (s.delay != 8'h00); // R10

	// Three receive timeouts counted in units of 16 bit periods.
	rxt_wait_timer #(.UNIT_LOG2(TIMEOUT_UNIT_LOG2)) u_rssi_timer (
		.clk   (clk),
		.rst   (rst),
		.tick  (s.bit_tick),
		.start (rx_entry),
		.stop  (rx_exit || rssi_event), // R7
		.limit (s.rssi_lim),
		.done  (rssi_done)
	);

	rxt_wait_timer #(.UNIT_LOG2(TIMEOUT_UNIT_LOG2)) u_pre_timer (
		.clk   (clk),
		.rst   (rst),
		.tick  (s.bit_tick),
		.start (rx_entry),
		.stop  (rx_exit || preamble_event), // R8
		.limit (s.pre_lim),
		.done  (pre_done)
	);

	rxt_wait_timer #(.UNIT_LOG2(TIMEOUT_UNIT_LOG2)) u_sync_timer (
		.clk   (clk),
		.rst   (rst),
		.tick  (s.bit_tick),
		.start (rx_entry),
		.stop  (rx_exit || sync_match_event), // R9
		.limit (s.sync_lim),
		.done  (sync_done)
	);

	// Restart delay counted in units of four bit periods.
	rxt_wait_timer #(.UNIT_LOG2(RESTART_UNIT_LOG2)) u_delay_timer (
		.clk   (clk),
		.rst   (rst),
		.tick  (s.bit_tick),
		.start (delay_start),
		.stop  (1'b0),
		.limit (s.delay),
		.done  (delay_done)
	);

	// Next-state logic for registers, timebase, restart and clock output.
	always_comb
	begin
		next_s = s;
		next_s.rx_prev = rx_mode;
		next_s.rdata = 8'h00;
		next_s.restart = 1'b0;
		next_s.cal = 1'b0;

		// The bit timebase follows the programmed bit rate.
		next_s.bit_tick = 1'b0;
		if (s.bit_cnt + 16'h0001 >= bit_period_cycles) // R17
		begin
			next_s.bit_cnt = 16'h0000;
			next_s.bit_tick = 1'b1;
		end
		else
			next_s.bit_cnt = s.bit_cnt + 16'h0001;

		// The correction loop updates first, so software has the last word.
		if (afc_load)
			next_s.corr = afc_value;

		// Register writes.
		if (wr)
		begin
			unique case (addr)
				ADDR_CORR_HIGH:  next_s.corr[15:8] = wdata; // R1
				ADDR_CORR_LOW:   next_s.corr[7:0] = wdata; // R1
				ADDR_CORR_CTRL:
					if (wdata[CLR_BIT] && rx_mode)
						next_s.corr = 16'h0000; // R14
				ADDR_PRE_CFG:    next_s.pre_cfg = wdata;
				ADDR_RSSI_TO:    next_s.rssi_lim = wdata;
				ADDR_PRE_TO:     next_s.pre_lim = wdata;
				ADDR_SYNC_TO:    next_s.sync_lim = wdata;
				ADDR_DELAY:      next_s.delay = wdata;
				ADDR_OSC:
				begin
					next_s.cal = wdata[CAL_BIT]; // R11
					next_s.clk_sel = wdata[2:0];
				end
				ADDR_SYNC_CFG:
					next_s.policy = wdata[POLICY_LSB +: 2]; // R15
				ADDR_IRQ_MASK:   next_s.mask = wdata[IRQ_W-1:0];
				default:         next_s.rdata = 8'h00;
			endcase
		end

		// Register reads; the error low byte comes from the snapshot.
		if (rd)
		begin
			unique case (addr)
				ADDR_CORR_HIGH:  next_s.rdata = s.corr[15:8];
				ADDR_CORR_LOW:   next_s.rdata = s.corr[7:0];
				ADDR_ERR_HIGH:
				begin
					next_s.rdata = freq_error_estimate[15:8]; // R3
					next_s.err_low = freq_error_estimate[7:0]; // R2
				end
				ADDR_ERR_LOW:    next_s.rdata = s.err_low; // R2
				ADDR_PRE_CFG:    next_s.rdata = s.pre_cfg;
				ADDR_RSSI_TO:    next_s.rdata = s.rssi_lim;
				ADDR_PRE_TO:     next_s.rdata = s.pre_lim;
				ADDR_SYNC_TO:    next_s.rdata = s.sync_lim;
				ADDR_DELAY:      next_s.rdata = s.delay;
				ADDR_OSC:        next_s.rdata = {5'h00, s.clk_sel}; // R11
				ADDR_SYNC_CFG:   next_s.rdata = {s.policy, 6'h00};
				ADDR_IRQ_STATUS: next_s.rdata = {4'h0, s.status};
				ADDR_IRQ_MASK:   next_s.rdata = {4'h0, s.mask};
				default:         next_s.rdata = 8'h00; // R14
			endcase
		end

		// Preamble detector control; gain control overrides during its phase.
		next_s.pre_run = agc_phase ? agc_detect_request
			: s.pre_cfg[PRE_EN_BIT]; // R4
		unique case (s.pre_cfg[PRE_LEN_LSB +: 2]) // R5
			2'h0:         next_s.pre_bytes = 2'h1;
			2'h1:         next_s.pre_bytes = 2'h2;
			2'h2:         next_s.pre_bytes = 2'h3;
			LEN_RESERVED: next_s.pre_bytes = 2'h1;
		endcase

		// Automatic restart sequencer.
		unique case (s.rs)
			RS_IDLE:
				if (restart_req)
				begin
					if (s.delay != 8'h00)
						next_s.rs = RS_DELAY; // R10
					else if (s.policy == POLICY_PLL)
						next_s.rs = RS_PLL;
					else
						next_s.restart = 1'b1;
				end
			RS_DELAY:
				if (delay_done)
				begin
					if (s.policy == POLICY_PLL)
						next_s.rs = RS_PLL;
					else
					begin
						next_s.restart = 1'b1; // R15
						next_s.rs = RS_IDLE;
					end
				end
			RS_PLL:
				if (pll_locked)
				begin
					next_s.restart = 1'b1; // R15
					next_s.rs = RS_IDLE;
				end
		endcase

		// Sticky status: write one to clear, a new event wins over the clear.
		if (wr && addr == ADDR_IRQ_STATUS)
			next_s.status = s.status & ~wdata[IRQ_W-1:0];
		next_s.status[IRQ_RSSI_TO] = next_s.status[IRQ_RSSI_TO] | rssi_done;
		next_s.status[IRQ_PRE_TO]  = next_s.status[IRQ_PRE_TO] | pre_done;
		next_s.status[IRQ_SYNC_TO] = next_s.status[IRQ_SYNC_TO] | sync_done;
		next_s.status[IRQ_RESTART] = next_s.status[IRQ_RESTART]
			| s.restart;
		next_s.timeout = rssi_done || pre_done || sync_done; // R7
		next_s.irq = |(s.status & s.mask);

		// RC clock input: three stages, a change counts when the last agree.
		next_s.rc_sync = {s.rc_sync[1:0], rc_osc};
		if (s.rc_sync[1] == s.rc_sync[2])
			next_s.rc_level = s.rc_sync[2];

		// Divider stage 0 toggles every cycle and stands for the reference.
		next_s.div = s.div + 6'h01;
		next_s.rc_en = (s.clk_sel == CLK_RC); // R13
		if (s.clk_sel == CLK_OFF)
			next_s.aux = 1'b0; // R13
		else if (s.clk_sel == CLK_RC)
			next_s.aux = s.rc_level; // R13
		else
			next_s.aux = s.div[s.clk_sel]; // R13
	end

	// State register.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s <= '0;
			s.pre_cfg <= RST_PRE_CFG;
			s.clk_sel <= RST_CLK_SEL;
			s.policy <= RST_POLICY;
			s.rs <= RS_IDLE;
		end
		else
			s <= next_s;
	end

	// Outputs come straight from the state register.
	assign rdata = s.rdata;
	assign freq_correction_value = s.corr;
	assign preamble_detect_run = s.pre_run;
	assign preamble_bytes_required = s.pre_bytes;
	assign preamble_chip_error_tolerance = s.pre_cfg[4:0]; // R6
	assign timeout_event = s.timeout;
	assign rx_restart = s.restart;
	assign rc_calibrate_start = s.cal;
	assign irq = s.irq;
	assign rc_osc_enable = s.rc_en;
	assign aux_clock_pin = s.aux;

	property p_cal_pulse;
		@(posedge clk) disable iff (rst)
		wr && addr == ADDR_OSC && wdata[CAL_BIT] |=> rc_calibrate_start;
	endproperty
	a_cal_pulse: assert property (p_cal_pulse) // R11
		else $error("calibration trigger did not start calibration");

	property p_cal_reads_zero;
		@(posedge clk) disable iff (rst)
		rd && addr == ADDR_OSC |=> rdata[CAL_BIT] == 1'b0;
	endproperty
	a_cal_reads_zero: assert property (p_cal_reads_zero) // R11
		else $error("calibration trigger read back as one");

	property p_corr_clear;
		@(posedge clk) disable iff (rst)
		wr && addr == ADDR_CORR_CTRL && wdata[CLR_BIT] && rx_mode
			|=> freq_correction_value == 16'h0000;
	endproperty
	a_corr_clear: assert property (p_corr_clear) // R14
		else $error("correction not cleared in receive mode");

	property p_corr_write;
		@(posedge clk) disable iff (rst)
		wr && addr == ADDR_CORR_HIGH
			|=> freq_correction_value[15:8] == $past(wdata);
	endproperty
	a_corr_write: assert property (p_corr_write) // R1
		else $error("correction high byte not replaced");

	property p_pre_enable;
		@(posedge clk) disable iff (rst)
		!rst && !agc_phase ##1 !agc_phase
			|-> preamble_detect_run == $past(s.pre_cfg[PRE_EN_BIT]);
	endproperty
	a_pre_enable: assert property (p_pre_enable) // R4
		else $error("preamble detector does not follow its enable");

	property p_timeout_out;
		@(posedge clk) disable iff (rst)
		rssi_done || pre_done || sync_done |=> timeout_event;
	endproperty
	a_timeout_out: assert property (p_timeout_out) // R7
		else $error("timeout expiry not reported");

	property p_clk_off;
		@(posedge clk) disable iff (rst)
		s.clk_sel == CLK_OFF ##1 s.clk_sel == CLK_OFF |=> !aux_clock_pin;
	endproperty
	a_clk_off: assert property (p_clk_off) // R13
		else $error("clock output active while disabled");
endmodule : rxt_regs
`default_nettype wire

// >>> testbench/rxt_regs_tb.sv
// Self-checking bench for the receiver timing register bank.
// Assumes the bank alone, driven by this bench through its byte port.
`default_nettype none
module rxt_regs_tb
	import rxt_pkg::*;
();
	timeunit 1ns;
	timeprecision 100ps;

	logic        clk, rst, wr, rd, rx_mode, rssi_event, preamble_event;
	logic        sync_match_event, valid_packet, pll_locked, agc_phase;
	logic        agc_detect_request, afc_load, preamble_detect_run;
	logic        timeout_event, rx_restart, rc_calibrate_start, irq;
	logic        rc_osc, rc_osc_enable, aux_clock_pin;
	logic [7:0]  addr, wdata, rdata, rv;
	logic [15:0] bit_period_cycles, afc_value, freq_error_estimate;
	logic [15:0] freq_correction_value;
	logic [1:0]  preamble_bytes_required;
	logic [4:0]  preamble_chip_error_tolerance;
	int          fails, comparisons, n, e, r;
	// Reset reads with their expected values, an unmapped address among
	// them, and the byte counts that the four length codes ask for.
	logic [7:0]  ra [10] = '{8'h1B, 8'h1C, 8'h1F, 8'h20, 8'h21, 8'h22,
		8'h23, 8'h24, 8'h1A, 8'h30};
	logic [7:0]  re [10] = '{8'h00, 8'h00, 8'hAA, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h07, 8'h00, 8'h00};
	logic [1:0]  pb [4] = '{2'h1, 2'h2, 2'h3, 2'h1};

	rxt_regs u_dut (
		.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .rx_mode(rx_mode),
		.bit_period_cycles(bit_period_cycles), .rssi_event(rssi_event),
		.preamble_event(preamble_event),
		.sync_match_event(sync_match_event), .valid_packet(valid_packet),
		.pll_locked(pll_locked), .agc_phase(agc_phase),
		.agc_detect_request(agc_detect_request), .afc_load(afc_load),
		.afc_value(afc_value), .freq_error_estimate(freq_error_estimate),
		.freq_correction_value(freq_correction_value),
		.preamble_detect_run(preamble_detect_run),
		.preamble_bytes_required(preamble_bytes_required),
		.preamble_chip_error_tolerance(preamble_chip_error_tolerance),
		.timeout_event(timeout_event), .rx_restart(rx_restart),
		.rc_calibrate_start(rc_calibrate_start), .irq(irq),
		.rc_osc(rc_osc), .rc_osc_enable(rc_osc_enable),
		.aux_clock_pin(aux_clock_pin)
	);

	// Main clock of 4 ns; the RC clock is exactly 16 main periods so a
	// 128-cycle window always holds the same number of its edges.
	always #2 clk = ~clk;
	always #32 rc_osc = ~rc_osc;

	task automatic check(input string name, input logic [15:0] seen, exp);
		comparisons++;
		if (seen !== exp)
		begin
			fails++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic end_sim;
		if (fails == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim

	task automatic cyc(input int c);
		repeat (c) @(posedge clk);
	endtask : cyc

	task automatic wr_reg(input logic [7:0] a, d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	// Read data is sampled just after the edge that registers it.
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg

	task automatic pulse(input int k);
		@(posedge clk);
		case (k)
			0: rssi_event <= 1'b1;
			1: preamble_event <= 1'b1;
			2: sync_match_event <= 1'b1;
			default: valid_packet <= 1'b1;
		endcase
		@(posedge clk);
		rssi_event       <= 1'b0;
		preamble_event   <= 1'b0;
		sync_match_event <= 1'b0;
		valid_packet     <= 1'b0;
	endtask : pulse

	// Bounded wait; n stays 0 when the pulse never shows. The cycle in
	// progress is looked at first, because a pulse may answer the very
	// edge that ended the caller's own request.
	task automatic wait_ev(input logic sel, input int max, output int n);
		n = 0;
		for (int i = 1; i <= max && n == 0; i++)
		begin
			#1 if ((sel ? rx_restart : timeout_event) === 1'b1) n = i;
			@(posedge clk);
		end
	endtask : wait_ev

	task automatic enter_rx;
		@(posedge clk);
		rx_mode <= 1'b0;
		cyc(2);
		rx_mode <= 1'b1;
	endtask : enter_rx

	task automatic restart_case(input logic [1:0] p, input logic [7:0] d,
		input int lo, hi);
		wr_reg(ADDR_SYNC_CFG, {p, 6'h00});
		wr_reg(ADDR_DELAY, d);
		pulse(3);
		wait_ev(1'b1, 60, n);
		check("restart_cycles", 16'(lo == 0 ? n == 0 : n >= lo && n <= hi),
			16'h1);
	endtask : restart_case

	// Watchdog well beyond the few thousand cycles the tests take.
	initial
	begin
		#200000;
		fails++;
		end_sim();
	end

	initial
	begin
		{clk, wr, rd, rx_mode, rssi_event, preamble_event} = '0;
		{sync_match_event, valid_packet, agc_phase, agc_detect_request} = '0;
		{afc_load, rc_osc, addr, wdata, afc_value, freq_error_estimate} = '0;
		rst = 1'b1;
		pll_locked = 1'b1;
		bit_period_cycles = 16'h0002;
		cyc(2);
		rst <= 1'b0;
		// Reset values, an unmapped address among them.
		for (int i = 0; i < 10; i++)
		begin
			rd_reg(ra[i], rv);
			check("reset_read", 16'(rv), 16'(re[i]));
		end
		rd_reg(ADDR_SYNC_CFG, rv);
		check("policy_reset", 16'(rv[7:6]), 16'(RST_POLICY));
		check("run_reset", 16'(preamble_detect_run), 16'h1);
		check("len_reset", 16'(preamble_bytes_required), 16'h2);
		check("tol_reset", 16'(preamble_chip_error_tolerance), 16'hA);
		check("aux_reset", 16'(aux_clock_pin), 16'h0);
		// Correction: byte writes, loop load, then clear only in receive.
		wr_reg(ADDR_CORR_HIGH, 8'h12);
		wr_reg(ADDR_CORR_LOW, 8'h34);
		#1 check("corr", freq_correction_value, 16'h1234);
		rd_reg(ADDR_CORR_HIGH, rv);
		check("corr_high", 16'(rv), 16'h12);
		@(posedge clk);
		afc_load  <= 1'b1;
		afc_value <= 16'hBEEF;
		@(posedge clk);
		afc_load <= 1'b0;
		wr_reg(ADDR_CORR_CTRL, 8'h02);
		#1 check("corr_kept", freq_correction_value, 16'hBEEF);
		rx_mode <= 1'b1;
		wr_reg(ADDR_CORR_CTRL, 8'h02);
		#1 check("corr_clr", freq_correction_value, 16'h0000);
		rd_reg(ADDR_CORR_CTRL, rv);
		check("clr_read", 16'(rv), 16'h00);
		rx_mode <= 1'b0;
		// Error readout: the low byte belongs to the high-byte read.
		freq_error_estimate <= 16'hA55A;
		rd_reg(ADDR_ERR_HIGH, rv);
		check("err_high", 16'(rv), 16'hA5);
		freq_error_estimate <= 16'h0000;
		rd_reg(ADDR_ERR_LOW, rv);
		check("err_low", 16'(rv), 16'h5A);
		// Length codes and tolerance, then gain control overriding.
		for (int c = 0; c < 4; c++)
		begin
			wr_reg(ADDR_PRE_CFG, {1'b1, 2'(c), 5'(c * 7 + 3)});
			cyc(2);
			check("len", 16'(preamble_bytes_required), 16'(pb[c]));
			check("tol", 16'(preamble_chip_error_tolerance),
				16'(c * 7 + 3));
		end
		agc_phase <= 1'b1;
		cyc(3);
		check("run_agc_off", 16'(preamble_detect_run), 16'h0);
		wr_reg(ADDR_PRE_CFG, 8'h0A);
		agc_detect_request <= 1'b1;
		cyc(3);
		check("run_agc_on", 16'(preamble_detect_run), 16'h1);
		agc_phase <= 1'b0;
		cyc(3);
		check("run_off", 16'(preamble_detect_run), 16'h0);
		// Each timeout with its own bit period: expiry, irq, stop cases.
		for (int k = 0; k < 3; k++)
		begin
			bit_period_cycles <= 16'(2 + k);
			wr_reg(ADDR_IRQ_MASK, 8'(1 << k));
			for (int j = 0; j < 3; j++)
				wr_reg(ADDR_RSSI_TO + 8'(j), j == k ? 8'h02 : 8'h00);
			enter_rx();
			wait_ev(1'b0, 300, n);
			e = 32 * (2 + k);
			check("to_cycles", 16'(n >= e - 2 - k && n <= e + 6 + k),
				16'h1);
			cyc(2);
			check("irq_set", 16'(irq), 16'h1);
			rd_reg(ADDR_IRQ_STATUS, rv);
			check("status", 16'(rv), 16'(1 << k));
			wr_reg(ADDR_IRQ_STATUS, 8'(1 << k));
			cyc(2);
			check("irq_clr", 16'(irq), 16'h0);
			enter_rx();
			cyc(10);
			pulse(k);
			wait_ev(1'b0, 150, n);
			check("to_stop_ev", 16'(n), 16'h0);
			enter_rx();
			cyc(10);
			rx_mode <= 1'b0;
			wait_ev(1'b0, 150, n);
			check("to_stop_rx", 16'(n), 16'h0);
		end
		wr_reg(ADDR_SYNC_TO, 8'h00);
		enter_rx();
		wait_ev(1'b0, 150, n);
		check("to_zero", 16'(n), 16'h0);
		rx_mode <= 1'b0;
		bit_period_cycles <= 16'h0002;
		// Restart policies and delay; status sticky, irq masked then not.
		wr_reg(ADDR_IRQ_MASK, 8'h00);
		restart_case(POLICY_NOWAIT, 8'h00, 1, 1);
		restart_case(POLICY_NOWAIT, 8'h03, 22, 30);
		restart_case(2'h0, 8'h00, 0, 0);
		restart_case(2'h3, 8'h00, 0, 0);
		pll_locked <= 1'b0;
		restart_case(POLICY_PLL, 8'h00, 0, 0);
		pll_locked <= 1'b1;
		wait_ev(1'b1, 10, n);
		check("restart_pll", 16'(n != 0), 16'h1);
		// Delay first, then the lock wait, with the lock already present.
		restart_case(POLICY_PLL, 8'h01, 8, 14);
		check("irq_masked", 16'(irq), 16'h0);
		wr_reg(ADDR_IRQ_MASK, 8'h08);
		cyc(2);
		check("irq_restart", 16'(irq), 16'h1);
		wr_reg(ADDR_IRQ_STATUS, 8'h08);
		cyc(2);
		check("irq_done", 16'(irq), 16'h0);
		// Calibration only from standby, with the receiver off.
		wr_reg(ADDR_OSC, 8'h0F);
		#1 check("cal_pulse", 16'(rc_calibrate_start), 16'h1);
		rd_reg(ADDR_OSC, rv);
		check("cal_read", 16'(rv), 16'h07);
		// Clock output: count rising edges in a fixed window per code.
		for (int c = 0; c < 8; c++)
		begin
			wr_reg(ADDR_OSC, 8'(c));
			cyc(8);
			r = 0;
			rv[0] = aux_clock_pin;
			repeat (128)
			begin
				@(posedge clk);
				#1 if (aux_clock_pin === 1'b1 && rv[0] === 1'b0) r++;
				rv[0] = aux_clock_pin;
			end
			e = c < 6 ? 128 >> (c + 1) : c == 6 ? 8 : 0;
			check("aux_rises", 16'(r), 16'(e));
			check("rc_en", 16'(rc_osc_enable), 16'(c == 6));
		end
		end_sim();
	end
endmodule : rxt_regs_tb
`default_nettype wire
